// ### hdl/tsc_cfg.svh
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
// Register offsets on the host port
`define TSC_A_MEM_ACCESS_DATA_REG   8'h00
`define TSC_A_MEM_ACCESS_ADDR_REG   8'h01
`define TSC_A_MEM_ACCESS_CTRL_REG   8'h02
`define TSC_A_INDICATE_CHANGE_FIFO 8'h03
`define TSC_A_ISTAE  8'h04
`define TSC_A_ISTAA  8'h05
`define TSC_A_MAIN_IRQ_STATUS   8'h06
`define TSC_A_DCE    8'h07
`define TSC_A_XDC    8'h08
`define TSC_A_COMMAND_REG   8'h09
`define TSC_A_TRANSMIT_FIFO  8'h0a
`define TSC_A_RECEIVE_FIFO  8'h0b
`define TSC_A_RECEIVE_BYTE_COUNT   8'h0c
// Access control operations (upper nibble) and codes (lower nibble)
`define TSC_OP_BOTH  4'h7
`define TSC_OP_DATA  4'h4
`define TSC_OP_READ  4'hc
`define TSC_OP_TRI   4'h6
`define TSC_CODE_SW  4'h1
`define TSC_CODE_CI  4'h8
`define TSC_TRI_ALL  4'h8
// Commands
`define TSC_CMD_XTF  8'h0a
`define TSC_CMD_RRES 8'h80
`define TSC_CMD_CRES 8'h10
// Status values and bit positions
`define TSC_ISTAE_CI 8'h40
`define TSC_XPR_BIT  4
`define TSC_RME_BIT  7
`define TSC_ARB_BIT  4
`define TSC_RECEIVE_STATUS_BYTE_OK  8'h80
`define TSC_FLAG     8'h7e
`define TSC_IDLE     8'hff
// Queue depths
`define TSC_CI_DEPTH 4'd8
`define TSC_RX_DATA  5'd15
`define TSC_RX_DEPTH 5'd16
`define TSC_TX_DEPTH 5'd16
`endif

// ### hdl/tsc_pkg.sv
package tsc_pkg;
    typedef struct packed {
        logic [7:0]        mem_access_data_reg;
        logic [7:0]        mem_access_addr_reg;
        logic [7:0]        mem_access_ctrl_reg;
        logic              rd_pend;
        logic [31:0]       drv;
        logic [7:0]        dce;
        logic [7:0]        transmit_channel_select;
        logic [7:0][7:0]   ci_q;
        logic [3:0]        ci_n;
        logic [7:0]        hdlc_a_irq_status;
        logic [15:0][7:0]  tx_q;
        logic [4:0]        tx_n;
        logic              tx_act;
        logic [15:0][7:0]  rx_q;
        logic [4:0]        rx_n;
        logic              rx_busy;
        logic [2:0]        rx_ch;
        logic [31:0][7:0]  pcm_in;
        logic [31:0][7:0]  pcm_out;
        logic [2:0]        dcl;
        logic [1:0]        fs;
        logic [1:0]        srx;
        logic [1:0]        prx;
        logic [7:0]        bitc;
        logic [7:0]        sh_in;
        logic [7:0]        pin;
        logic [7:0]        up_byte;
        logic [4:0]        up_slot;
        logic [11:0]       dn_ent;
        logic [7:0]        sub_sh;
        logic [7:0]        pcm_sh;
        logic              pcm_drv;
        logic              sub_tx;
        logic              pcm_tx;
        logic              pcm_oe_n;
        logic              irq;
        logic [7:0]        rdata;
    } tsc_st_t;

    typedef struct packed {
        logic [255:0][7:0] data;
        logic [255:0][3:0] code;
        logic [7:0]        rdata_h;
        logic [3:0]        rcode_h;
        logic [7:0]        rdata_l;
        logic [3:0]        rcode_l;
    } tsc_mem_t;
endpackage : tsc_pkg

// ### hdl/tsc_cm_if.sv
`timescale 1ns/10ps
interface tsc_cm_if;
    logic       we_d;
    logic       we_c;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [3:0] wcode;
    logic [7:0] raddr_h;
    logic [7:0] rdata_h;
    logic [3:0] rcode_h;
    logic [7:0] raddr_l;
    logic [7:0] rdata_l;
    logic [3:0] rcode_l;
    modport ctl (output we_d, we_c, waddr, wdata, wcode, raddr_h, raddr_l,
                 input rdata_h, rcode_h, rdata_l, rcode_l);
    modport mem (input we_d, we_c, waddr, wdata, wcode, raddr_h, raddr_l,
                 output rdata_h, rcode_h, rdata_l, rcode_l);
endinterface : tsc_cm_if

// ### hdl/tsc_cm_mem.sv
`timescale 1ns/10ps
module tsc_cm_mem
    import tsc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Connection memory port
    tsc_cm_if.mem    cm
);
    tsc_mem_t s_r;
    tsc_mem_t s_nxt;

    // Data and code fields write separately; reads return old contents
    always_comb
    begin
        s_nxt = s_r;
        if (cm.we_d)
            s_nxt.data[cm.waddr] = cm.wdata;
        if (cm.we_c)
            s_nxt.code[cm.waddr] = cm.wcode;
        s_nxt.rdata_h = s_r.data[cm.raddr_h];
        s_nxt.rcode_h = s_r.code[cm.raddr_h];
        s_nxt.rdata_l = s_r.data[cm.raddr_l];
        s_nxt.rcode_l = s_r.code[cm.raddr_l];
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign cm.rdata_h = s_r.rdata_h;
    assign cm.rcode_h = s_r.rcode_h;
    assign cm.rdata_l = s_r.rdata_l;
    assign cm.rcode_l = s_r.rcode_l;
endmodule : tsc_cm_mem

// ### hdl/tsc_switch.sv
// Function
// - Control 71h writes data and code; code 1 means 64 kbit/s switching.
// - Upstream entry address names subscriber slot; 80h slot 0, 90h slot 4.
// - Upstream entry data names destination PCM slot; 81h slot 1, 88h slot 2.
// - Downstream data names source PCM slot, address names subscriber slot.
// - PCM slot stays high impedance until its tristate entry is changed.
// - Control 48h writes only the data field, code kept.
// - Control C8h loads addressed data field into the access data register.
// - Downstream C/I byte F3h goes out as code 1100 with blocked bit.
// - Upstream C/I change queues an entry; extended status reads 40h.
// - Each queued entry is the upstream address of the changed slot.
// - Interrupt stays high while change entries remain unread.
// - Upstream C/I byte stored whole, read back via access data register.
// - Arbiter enable register bit n enables D-channel of channel n.
// - Enabled channel's downstream arbitration bit is sent as available.
// - Transmit select register steers controller A output to one channel.
// - Command 0Ah sends transmit FIFO as transparent frame with end.
// - After the frame leaves the FIFO, status bit 10h is set.
// - End of a received frame raises receive message end.
// - Receive count includes the appended receive status byte.
// - Command 80h empties the whole receive FIFO and aborts a frame in reception.
`timescale 1ns/10ps
`include "tsc_cfg.svh"
module tsc_switch
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Host register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            irq,
    // Serial link pins
    input  wire logic       link_clk_pin,
    input  wire logic       fsync_pin,
    input  wire logic       sub_rx_pin,
    output logic            sub_tx_pin,
    input  wire logic       pcm_rx_pin,
    output logic            pcm_tx_pin,
    output logic            pcm_tx_oe_n
);
    tsc_st_t    r;
    tsc_st_t    n;
    tsc_cm_if   cm ();
    logic       rise;
    logic       fall;
    logic [4:0] slot;
    logic [2:0] bp;
    logic [7:0] nb;
    logic [4:0] ns;
    logic [4:0] us;
    int         i;

    tsc_cm_mem u_mem (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .cm       (cm.mem)
    );

    // Address of a subscriber slot entry
    function automatic logic [7:0] cm_addr(input logic up,
                                           input logic [4:0] s);
        cm_addr = {up, s[4:1], 2'b00, s[0]};
    endfunction : cm_addr

    // Slot named by an entry address or PCM data value
    function automatic logic [4:0] slot_of(input logic [7:0] a);
        slot_of = {a[6:3], a[0]};
    endfunction : slot_of

    always_comb
    begin
        n = r;
        nb = 8'h00;
        ns = 5'h00;
        us = r.up_slot;
        cm.we_d = 1'b0;
        cm.we_c = 1'b0;
        cm.waddr = r.mem_access_addr_reg;
        cm.wdata = r.mem_access_data_reg;
        cm.wcode = r.mem_access_ctrl_reg[3:0];
        cm.raddr_h = r.mem_access_addr_reg;
        n.rdata = 8'h00;
        n.dcl = {r.dcl[1:0], link_clk_pin};
        n.fs = {r.fs[0], fsync_pin};
        n.srx = {r.srx[0], sub_rx_pin};
        n.prx = {r.prx[0], pcm_rx_pin};
        rise = r.dcl[1] & ~r.dcl[2];
        fall = ~r.dcl[1] & r.dcl[2];
        slot = r.bitc[7:3];
        bp = r.bitc[2:0];
        cm.raddr_l = (bp >= 3'd4) ? cm_addr(1'b1, r.up_slot)
                                  : cm_addr(1'b0, slot + 5'd1);
        n.rd_pend = 1'b0;
        if (r.rd_pend)
            n.mem_access_data_reg = cm.rdata_h;
        if (wr)
        begin
            case (addr)
            `TSC_A_MEM_ACCESS_DATA_REG: n.mem_access_data_reg = wdata;
            `TSC_A_MEM_ACCESS_ADDR_REG: n.mem_access_addr_reg = wdata;
            `TSC_A_MEM_ACCESS_CTRL_REG:
            begin
                n.mem_access_ctrl_reg = wdata;
                cm.wcode = wdata[3:0];
                case (wdata[7:4])
                `TSC_OP_BOTH:
                begin
                    cm.we_d = 1'b1;
                    cm.we_c = 1'b1;
                end
                `TSC_OP_DATA: cm.we_d = 1'b1;
                `TSC_OP_READ: n.rd_pend = 1'b1;
                `TSC_OP_TRI:
                begin
                    if (wdata[3:0] == `TSC_TRI_ALL)
                        n.drv = {32{|r.mem_access_data_reg[3:0]}};
                    else
                        n.drv[slot_of(r.mem_access_addr_reg)] = |r.mem_access_data_reg[3:0];
                end
                default: ;
                endcase
            end
            `TSC_A_DCE: n.dce = wdata;
            `TSC_A_XDC: n.transmit_channel_select = wdata;
            `TSC_A_COMMAND_REG:
            begin
                if (wdata == `TSC_CMD_XTF)
                    n.tx_act = 1'b1;
                if (wdata == `TSC_CMD_RRES)
                begin
                    n.rx_n = 5'd0;
                    n.rx_busy = 1'b0;
                end
                if (wdata == `TSC_CMD_CRES)
                    n.ci_n = 4'd0;
            end
            `TSC_A_TRANSMIT_FIFO:
            begin
                if (n.tx_n < `TSC_TX_DEPTH && !r.tx_act)
                begin
                    n.tx_q[n.tx_n[3:0]] = wdata;
                    n.tx_n = n.tx_n + 5'd1;
                end
            end
            default: ;
            endcase
        end
        if (rd)
        begin
            case (addr)
            `TSC_A_MEM_ACCESS_DATA_REG: n.rdata = r.mem_access_data_reg;
            `TSC_A_MEM_ACCESS_ADDR_REG: n.rdata = r.mem_access_addr_reg;
            `TSC_A_MEM_ACCESS_CTRL_REG: n.rdata = r.mem_access_ctrl_reg;
            `TSC_A_INDICATE_CHANGE_FIFO:
            begin
                if (r.ci_n != 4'd0)
                begin
                    n.rdata = r.ci_q[0];
                    for (i = 0; i < 7; i++)
                        n.ci_q[i] = n.ci_q[i + 1];
                    n.ci_n = n.ci_n - 4'd1;
                end
            end
            `TSC_A_ISTAE:
                n.rdata = (r.ci_n != 4'd0) ? `TSC_ISTAE_CI : 8'h00;
            `TSC_A_ISTAA:
            begin
                n.rdata = r.hdlc_a_irq_status;
                n.hdlc_a_irq_status = 8'h00;
            end
            `TSC_A_MAIN_IRQ_STATUS: n.rdata = {6'h00, |r.hdlc_a_irq_status, 1'b0};
            `TSC_A_DCE: n.rdata = r.dce;
            `TSC_A_XDC: n.rdata = r.transmit_channel_select;
            `TSC_A_RECEIVE_FIFO:
            begin
                if (r.rx_n != 5'd0)
                begin
                    n.rdata = r.rx_q[0];
                    for (i = 0; i < 15; i++)
                        n.rx_q[i] = n.rx_q[i + 1];
                    n.rx_n = n.rx_n - 5'd1;
                end
            end
            `TSC_A_RECEIVE_BYTE_COUNT: n.rdata = {3'h0, r.rx_n};
            default: n.rdata = 8'h00;
            endcase
        end
        // Receive side samples on the falling link clock edge
        if (fall)
        begin
            n.sh_in = {r.sh_in[6:0], r.srx[1]};
            n.pin = {r.pin[6:0], r.prx[1]};
            if (bp == 3'd7)
            begin
                n.up_byte = n.sh_in;
                n.up_slot = slot;
                n.pcm_in[slot] = n.pin;
            end
        end
        // Transmit side and slot processing on the rising edge
        if (rise)
        begin
            nb = r.fs[1] ? 8'h00 : r.bitc + 8'd1;
            n.bitc = nb;
            if (bp == 3'd2)
                n.dn_ent = {cm.rcode_l, cm.rdata_l};
            if (bp == 3'd6)
            begin
                if (cm.rcode_l == `TSC_CODE_SW)
                    n.pcm_out[slot_of(cm.rdata_l)] = r.up_byte;
                else if (cm.rcode_l == `TSC_CODE_CI &&
                         r.up_byte != cm.rdata_l &&
                         !(cm.we_d || cm.we_c))
                begin
                    cm.we_d = 1'b1;
                    cm.waddr = cm_addr(1'b1, us);
                    cm.wdata = r.up_byte;
                    if (n.ci_n < `TSC_CI_DEPTH)
                    begin
                        n.ci_q[n.ci_n[2:0]] = cm_addr(1'b1, us);
                        n.ci_n = n.ci_n + 4'd1;
                    end
                end
                if (us[1:0] == 2'd3 && r.dce[us[4:2]] &&
                    (!r.rx_busy || r.rx_ch == us[4:2]))
                begin
                    if (r.up_byte == `TSC_FLAG)
                    begin
                        if (r.rx_busy)
                        begin
                            n.rx_q[n.rx_n[3:0]] = `TSC_RECEIVE_STATUS_BYTE_OK;
                            n.rx_n = n.rx_n + 5'd1;
                            n.hdlc_a_irq_status[`TSC_RME_BIT] = 1'b1;
                            n.rx_busy = 1'b0;
                        end
                    end
                    else if (r.up_byte != `TSC_IDLE &&
                             n.rx_n < `TSC_RX_DATA)
                    begin
                        n.rx_q[n.rx_n[3:0]] = r.up_byte;
                        n.rx_n = n.rx_n + 5'd1;
                        n.rx_busy = 1'b1;
                        n.rx_ch = us[4:2];
                    end
                end
            end
            if (nb[2:0] == 3'd0)
            begin
                ns = nb[7:3];
                if (r.dn_ent[11:8] == `TSC_CODE_SW)
                    n.sub_sh = r.pcm_in[slot_of(r.dn_ent[7:0])];
                else
                    n.sub_sh = r.dn_ent[7:0];
                if (ns[1:0] == 2'd2 && r.dce[ns[4:2]])
                    n.sub_sh[`TSC_ARB_BIT] = 1'b0;
                if (ns[1:0] == 2'd3)
                begin
                    n.sub_sh = `TSC_IDLE;
                    if (r.tx_act && ns[4:2] == r.transmit_channel_select[2:0])
                    begin
                        if (n.tx_n != 5'd0)
                        begin
                            n.sub_sh = n.tx_q[0];
                            for (i = 0; i < 15; i++)
                                n.tx_q[i] = n.tx_q[i + 1];
                            n.tx_n = n.tx_n - 5'd1;
                        end
                        else
                        begin
                            n.sub_sh = `TSC_FLAG;
                            n.tx_act = 1'b0;
                            n.hdlc_a_irq_status[`TSC_XPR_BIT] = 1'b1;
                        end
                    end
                end
                n.pcm_sh = r.pcm_out[ns];
                n.pcm_drv = r.drv[ns];
            end
            else
            begin
                n.sub_sh = {r.sub_sh[6:0], 1'b1};
                n.pcm_sh = {r.pcm_sh[6:0], 1'b1};
            end
            n.sub_tx = n.sub_sh[7];
            n.pcm_tx = n.pcm_sh[7];
            n.pcm_oe_n = ~n.pcm_drv;
        end
        n.irq = (n.ci_n != 4'd0) || (n.hdlc_a_irq_status != 8'h00);
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.sub_tx <= 1'b1;
            r.pcm_oe_n <= 1'b1;
        end
        else
            r <= n;
    end

    assign rdata = r.rdata;
    assign irq = r.irq;
    assign sub_tx_pin = r.sub_tx;
    assign pcm_tx_pin = r.pcm_tx;
    assign pcm_tx_oe_n = r.pcm_oe_n;

    logic mem_access_ctrl_reg_wr;
    assign mem_access_ctrl_reg_wr = wr && addr == `TSC_A_MEM_ACCESS_CTRL_REG;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_both_fields: assert property (mem_access_ctrl_reg_wr && wdata == 8'h71 |->
        cm.we_d && cm.we_c && cm.wcode == 4'h1 && cm.wdata == r.mem_access_data_reg)
        else $error("both fields not written");
    chk_data_only: assert property (mem_access_ctrl_reg_wr && wdata == 8'h48 |->
        cm.we_d && !cm.we_c && cm.wdata == r.mem_access_data_reg)
        else $error("data-only write wrong");
    chk_read_back: assert property (mem_access_ctrl_reg_wr && wdata == 8'hc8 |=>
        ##1 r.mem_access_data_reg == $past(cm.rdata_h))
        else $error("read into data register failed");
    chk_irq_pending: assert property (r.ci_n != 4'd0 |-> r.irq)
        else $error("interrupt dropped with entries");
    chk_ci_status: assert property (rd && addr == `TSC_A_ISTAE &&
        r.ci_n != 4'd0 |=> rdata == 8'h40)
        else $error("extended status not 40h");
    chk_pcm_hiz: assert property (r.drv == 32'h0 [*2] |-> pcm_tx_oe_n)
        else $error("PCM driven while high impedance");
    chk_xpr_end: assert property ($rose(r.hdlc_a_irq_status[4]) |->
        $past(r.tx_act) && r.tx_n == 5'd0)
        else $error("pool ready without frame end");
    chk_rme_status: assert property ($rose(r.hdlc_a_irq_status[7]) |->
        r.rx_n != 5'd0 && r.rx_q[r.rx_n[3:0] - 4'd1] == 8'h80)
        else $error("status byte missing");
    chk_rx_release: assert property (wr && addr == `TSC_A_COMMAND_REG &&
        wdata == 8'h80 |=> r.rx_n == 5'd0)
        else $error("receive FIFO not released");

    cov_three_changes: cover property (r.ci_n == 4'd3);
    cov_rme: cover property ($rose(r.hdlc_a_irq_status[7]));
    cov_xpr: cover property ($rose(r.hdlc_a_irq_status[4]));
    cov_pcm_drive: cover property ($fell(pcm_tx_oe_n));
endmodule : tsc_switch

// ### test/tsc_link_model.sv
`timescale 1ns/10ps
module tsc_link_model
(
    // Link pins
    output logic                  link_clk,
    output logic                  fsync,
    output logic                  sub_rx,
    output logic                  pcm_rx,
    input  wire logic             sub_tx,
    input  wire logic             pcm_tx,
    input  wire logic             pcm_oe_n,
    // Slot contents sent and seen
    input  wire logic [31:0][7:0] up_bytes,
    input  wire logic [31:0][7:0] pcm_bytes,
    output logic      [31:0][7:0] dn_seen,
    output logic      [31:0][7:0] pcm_seen,
    output logic      [31:0]      pcm_drv,
    output logic      [15:0]      frames
);
    logic [7:0] dsh;
    logic [7:0] psh;
    logic       pd;
    int         p;

    initial
    begin
        link_clk = 1'b0;
        fsync = 1'b1;
        sub_rx = 1'b1;
        pcm_rx = 1'b1;
        dn_seen = '0;
        pcm_seen = '0;
        pcm_drv = '0;
        frames = '0;
        dsh = '0;
        psh = '0;
        pd = 1'b0;
        #3;
        forever
        begin
            for (int i = 0; i < 256; i++)
            begin
                // Outputs still hold the previous bit at this rise
                link_clk = 1'b1;
                p = (i + 255) % 256;
                dsh = {dsh[6:0], sub_tx};
                psh = {psh[6:0], pcm_tx};
                pd = pd | (pcm_oe_n === 1'b0);
                if (p % 8 == 7)
                begin
                    dn_seen[p / 8] = dsh;
                    pcm_seen[p / 8] = psh;
                    pcm_drv[p / 8] = pd;
                    pd = 1'b0;
                end
                if (i == 0)
                    frames = frames + 16'h1;
                // Bytes go out most significant bit first
                sub_rx = up_bytes[i / 8][7 - i % 8];
                pcm_rx = pcm_bytes[i / 8][7 - i % 8];
                #32;
                link_clk = 1'b0;
                fsync = (i == 255);
                #32;
            end
        end
    end
endmodule : tsc_link_model

// ### test/tsc_switch_tb.sv
`timescale 1ns/10ps
`include "tsc_cfg.svh"
module tsc_switch_tb;
    logic             core_clk;
    logic             reset_n;
    logic [7:0]       addr;
    logic [7:0]       wdata;
    logic             wr;
    logic             rd;
    logic [7:0]       rdata;
    logic             irq;
    logic             link_clk, fsync, sub_rx, sub_tx, pcm_rx, pcm_tx, oe_n;
    logic [31:0][7:0] up_bytes, pcm_bytes, dn_seen, pcm_seen;
    logic [31:0]      pcm_drv;
    logic [15:0]      frames;
    logic [7:0]       q[$];
    logic [7:0]       txe[4] = '{8'h11, 8'h22, 8'h33, `TSC_FLAG};
    int               num_errors = 0;
    int               total_checks = 0;

    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    tsc_switch dut
    (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .addr         (addr),
        .wdata        (wdata),
        .wr           (wr),
        .rd           (rd),
        .rdata        (rdata),
        .irq          (irq),
        .link_clk_pin (link_clk),
        .fsync_pin    (fsync),
        .sub_rx_pin   (sub_rx),
        .sub_tx_pin   (sub_tx),
        .pcm_rx_pin   (pcm_rx),
        .pcm_tx_pin   (pcm_tx),
        .pcm_tx_oe_n  (oe_n)
    );

    tsc_link_model far
    (
        .link_clk  (link_clk),
        .fsync     (fsync),
        .sub_rx    (sub_rx),
        .pcm_rx    (pcm_rx),
        .sub_tx    (sub_tx),
        .pcm_tx    (pcm_tx),
        .pcm_oe_n  (oe_n),
        .up_bytes  (up_bytes),
        .pcm_bytes (pcm_bytes),
        .dn_seen   (dn_seen),
        .pcm_seen  (pcm_seen),
        .pcm_drv   (pcm_drv),
        .frames    (frames)
    );

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        chk(what, e, rdata);
    endtask : rchk

    task automatic cm(input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] op);
        wreg(`TSC_A_MEM_ACCESS_DATA_REG, d);
        wreg(`TSC_A_MEM_ACCESS_ADDR_REG, a);
        wreg(`TSC_A_MEM_ACCESS_CTRL_REG, op);
    endtask : cm

    task automatic wait_frames(input int n);
        repeat (n)
            @(frames);
    endtask : wait_frames

    task automatic send_d(input logic [7:0] b);
        up_bytes[3] = b;
        wait_frames(1);
    endtask : send_d

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    initial
    begin
        #780000;
        num_errors++;
        $display("watchdog expired");
        end_of_test();
    end

    initial
    begin
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        up_bytes = {32{`TSC_IDLE}};
        pcm_bytes = {32{`TSC_IDLE}};
        repeat (10) @(posedge core_clk);
        chk("rdata in reset", 8'h00, rdata);
        chk("irq in reset", 8'h00, {7'h0, irq});
        chk("oe_n in reset", 8'h01, {7'h0, oe_n});
        reset_n <= 1'b1;
        rchk("unmapped", 8'hff, 8'h00);
        rchk("change status", `TSC_A_ISTAE, 8'h00);
        $display("test reset done");

        // Connections in both directions, PCM slots still high impedance
        up_bytes[0] = 8'ha5;
        up_bytes[4] = 8'h3c;
        pcm_bytes[1] = 8'hc3;
        pcm_bytes[2] = 8'h5a;
        cm(8'h80, 8'h81, 8'h71);
        cm(8'h90, 8'h88, 8'h71);
        cm(8'h00, 8'h08, 8'h71);
        cm(8'h10, 8'h01, 8'h71);
        wait_frames(3);
        chk("pcm1 drive", 8'h00, {7'h0, pcm_drv[1]});
        chk("pcm2 drive", 8'h00, {7'h0, pcm_drv[2]});
        chk("dn slot0", 8'h5a, dn_seen[0]);
        chk("dn slot4", 8'hc3, dn_seen[4]);
        cm(8'h01, 8'h0f, 8'h60);
        cm(8'h08, 8'h0f, 8'h60);
        wait_frames(3);
        chk("pcm1 drive", 8'h01, {7'h0, pcm_drv[1]});
        chk("pcm3 drive", 8'h00, {7'h0, pcm_drv[3]});
        chk("pcm slot1", 8'ha5, pcm_seen[1]);
        chk("pcm slot2", 8'h3c, pcm_seen[2]);
        $display("test switching done");

        // Data-only write keeps the switching code; read back the field
        cm(8'h00, 8'h01, 8'h48);
        cm(8'h08, 8'hf3, 8'h48);
        cm(8'h18, 8'hf3, 8'h48);
        wait_frames(3);
        chk("dn slot0", 8'hc3, dn_seen[0]);
        chk("dn c/i 0", 8'hf3, dn_seen[2]);
        chk("dn c/i 1", 8'hf3, dn_seen[6]);
        cm(8'h00, 8'h77, 8'hc8);
        rchk("data field", `TSC_A_MEM_ACCESS_DATA_REG, 8'h01);
        wreg(`TSC_A_DCE, 8'h01);
        wait_frames(2);
        chk("dn c/i 0", 8'he3, dn_seen[2]);
        chk("dn c/i 1", 8'hf3, dn_seen[6]);
        wreg(`TSC_A_DCE, 8'h03);
        wait_frames(2);
        chk("dn c/i 1", 8'he3, dn_seen[6]);
        rchk("arbiter enable", `TSC_A_DCE, 8'h03);
        $display("test memory and arbiter done");

        // Upstream indication changes queue one entry each
        cm(8'h88, `TSC_IDLE, 8'h78);
        cm(8'h98, `TSC_IDLE, 8'h78);
        wait_frames(2);
        chk("irq idle", 8'h00, {7'h0, irq});
        up_bytes[6] = 8'hfb;
        wait_frames(2);
        up_bytes[2] = 8'hf3;
        up_bytes[6] = 8'hf3;
        wait_frames(2);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("change status", `TSC_A_ISTAE, `TSC_ISTAE_CI);
        rchk("change entry", `TSC_A_INDICATE_CHANGE_FIFO, 8'h98);
        rchk("change entry", `TSC_A_INDICATE_CHANGE_FIFO, 8'h88);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("change entry", `TSC_A_INDICATE_CHANGE_FIFO, 8'h98);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq", 8'h00, {7'h0, irq});
        rchk("change empty", `TSC_A_INDICATE_CHANGE_FIFO, 8'h00);
        rchk("change status", `TSC_A_ISTAE, 8'h00);
        cm(8'h98, 8'h00, 8'hc8);
        rchk("up c/i", `TSC_A_MEM_ACCESS_DATA_REG, 8'hf3);
        $display("test indication done");

        // Frame steered to channel 1, then transmit pool ready
        wreg(`TSC_A_XDC, 8'h01);
        rchk("tx select", `TSC_A_XDC, 8'h01);
        for (int k = 0; k < 3; k++)
            wreg(`TSC_A_TRANSMIT_FIFO, txe[k]);
        wreg(`TSC_A_COMMAND_REG, `TSC_CMD_XTF);
        q = {};
        repeat (6)
        begin
            wait_frames(1);
            chk("d slot 3", `TSC_IDLE, dn_seen[3]);
            if (dn_seen[7] !== `TSC_IDLE)
                q.push_back(dn_seen[7]);
        end
        chk("tx count", 8'h04, 8'(q.size()));
        for (int k = 0; k < 4; k++)
            chk("tx byte", txe[k], q[k]);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("hdlc status", `TSC_A_ISTAA, 8'h10);
        rchk("hdlc status", `TSC_A_ISTAA, 8'h00);
        $display("test transmit done");

        // Received frames from channel 0
        send_d(8'ha1);
        send_d(8'hb2);
        send_d(`TSC_FLAG);
        send_d(`TSC_IDLE);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("main status", `TSC_A_MAIN_IRQ_STATUS, 8'h02);
        rchk("hdlc status", `TSC_A_ISTAA, 8'h80);
        rchk("rx count", `TSC_A_RECEIVE_BYTE_COUNT, 8'h03);
        rchk("rx byte", `TSC_A_RECEIVE_FIFO, 8'ha1);
        rchk("rx byte", `TSC_A_RECEIVE_FIFO, 8'hb2);
        rchk("rx status", `TSC_A_RECEIVE_FIFO, `TSC_RECEIVE_STATUS_BYTE_OK);
        wreg(`TSC_A_COMMAND_REG, `TSC_CMD_RRES);
        send_d(8'hc4);
        send_d(`TSC_FLAG);
        send_d(`TSC_IDLE);
        rchk("rx count", `TSC_A_RECEIVE_BYTE_COUNT, 8'h02);
        rchk("rx byte", `TSC_A_RECEIVE_FIFO, 8'hc4);
        wreg(`TSC_A_COMMAND_REG, `TSC_CMD_RRES);
        rchk("rx count", `TSC_A_RECEIVE_BYTE_COUNT, 8'h00);
        rchk("rx empty", `TSC_A_RECEIVE_FIFO, 8'h00);
        $display("test receive done");
        end_of_test();
    end
endmodule : tsc_switch_tb
